// [dv/can_bit_timing_error_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_error_status_tb;
  import can_bt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, cfg;
  logic [8:0] tx_err_count = '0;
  logic [7:0] rx_err_count = '0;
  logic [NFIFO-1:0] fifo_event = '0, fifo_event_en = '0, fifo_overflow = '0, ev, en, ov;
  wire logic awready, wready, bvalid, arready, rvalid, can_rx, tq_tick, sample_point;
  wire logic triple_sample_sel, sampled_bit, wake_detect;
  logic wk_on = 1'b0, wk_filt = 1'b0, wk_exp = 1'b0; // wake check enable, filter setting, expected pulse
  int low_run = 0; // consecutive low samples of the bus line
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] phase_seg1_tq, phase_seg2_tq;
  wire logic [4:0] quanta_per_bit;
  wire logic [2:0] operating_mode_field;
  int errors = 0, samples_checked = 0, seed = 83;
  logic [33:0] exp_q [$]; // expected {rresp, rdata}, oldest first
  logic [2:0] s1, s2f;
  logic [4:0] e1, e2;
  logic sp_d = 1'b0, rx_d = 1'b1;
  logic [8:0] tx_tab [8] = '{9'h000, 9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h12C};
  logic [7:0] rx_tab [8] = '{8'h80, 8'h7F, 8'h60, 8'h5F, 8'h00, 8'hFF, 8'h61, 8'h9A};

  can_bit_timing_error_status dut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tx_err_count(tx_err_count), .rx_err_count(rx_err_count), .fifo_event(fifo_event),
    .fifo_event_en(fifo_event_en), .fifo_overflow(fifo_overflow),
    .can_rx(can_rx), .tq_tick(tq_tick), .sample_point(sample_point),
    .phase_seg1_tq(phase_seg1_tq), .phase_seg2_tq(phase_seg2_tq), .quanta_per_bit(quanta_per_bit),
    .triple_sample_sel(triple_sample_sel), .sampled_bit(sampled_bit), .wake_detect(wake_detect),
    .operating_mode_field(operating_mode_field));

  can_node_model node (.aclk(aclk), .aresetn(aresetn), .can_rx(can_rx), .tq_tick(tq_tick),
    .sample_point(sample_point));

  // free-running 125 MHz clock
  initial forever #4 aclk = ~aclk;

  // verdict and end of run
  task automatic results();
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // single compare for every kind of result, widened to 34 bits
  task automatic chk(input logic [33:0] got, input logic [33:0] want, input string what);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // a bus wait that ran out ends the run
  task automatic stall();
    errors++;
    $display("unexpected at %0t: bus wait ran out", $time);
    results();
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) stall();
  endtask

  // read: the expectation is queued before the request goes out
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] e);
    int n;
    @(posedge aclk);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) stall();
  endtask

  // expected error state word from the two counts
  function automatic logic [31:0] err_exp(input logic [8:0] t, input logic [7:0] r);
    logic tw, rw;
    tw = t >= 9'h060 && t < 9'h080;
    rw = r >= 8'h60 && r < 8'h80;
    err_exp = {10'h000, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw, tw | rw, t >= 9'h100 ? 8'hFF : t[7:0], r};
  endfunction

  // watcher: read answers against the queue, sampled bus level one cycle after the sample point
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF, "read");
    if (sp_d && aresetn) chk(34'(sampled_bit), 34'(rx_d), "sample");
    if (wk_on && aresetn) chk(34'(wake_detect), 34'(wk_exp), "wake");
    // filtered: thirteenth low in a row; unfiltered: first low after high
    wk_exp <= wk_filt ? (!can_rx && low_run == WAKE_FILT_CYC - 1) : (rx_d && !can_rx);
    low_run <= can_rx ? 0 : low_run + 1;
    sp_d <= sample_point;
    rx_d <= can_rx;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTL, 34'h000800000);
    rd(OFS_CFG, 34'h000000000);
    // segment lengths, auto segment 2, bit time; software keeps prescaler >= 2 and prop >= 5 TQ
    for (int i = 0; i < 8; i++) begin
      s1 = i[2:0];
      s2f = 3'($random(seed));
      s2f = (s2f > s1) ? s1 : s2f;
      cfg = ($random(seed) & 32'h0040C73F) | 32'h00000402 | {13'h0, s2f, 2'b00, s1, 11'h0};
      wr(OFS_CFG, cfg);
      repeat (3) @(posedge aclk);
      e1 = 5'(s1) + 5'h1;
      e2 = cfg[15] ? 5'(s2f) + 5'h1 : (e1 > 5'h2 ? e1 : 5'h2);
      chk(34'(phase_seg1_tq), 34'(e1), "seg1");
      chk(34'(phase_seg2_tq), 34'(e2), "seg2");
      chk(34'(quanta_per_bit), 34'(5'h2 + 5'(cfg[10:8]) + e1 + e2), "bit time");
      chk(34'(triple_sample_sel), 34'(cfg[14]), "triple");
      rd(OFS_CFG, {2'b00, cfg});
    end
    // leaving configuration mode locks the timing register
    wr(OFS_CTL, 32'hFFFFFFFF);
    rd(OFS_CTL, 34'h000E00000);
    wr(OFS_CFG, 32'h00000000);
    rd(OFS_CFG, {2'b00, cfg});
    wr(OFS_CTL, 32'h00800000);
    chk(34'(operating_mode_field), 34'(MODE_CONFIG), "mode");
    wr(OFS_CFG, 32'h00000000);
    rd(OFS_CFG, 34'h000000000);
    // error counters and flags across every threshold; writes must not stick
    wr(OFS_ERR, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      tx_err_count <= tx_tab[i];
      rx_err_count <= rx_tab[i];
      rd(OFS_ERR, {2'b00, err_exp(tx_tab[i], rx_tab[i])});
    end
    // per-fifo pending and overflow bits
    for (int i = 0; i < 4; i++) begin
      ev = 16'($random(seed));
      en = 16'($random(seed));
      ov = 16'($random(seed));
      fifo_event <= ev;
      fifo_event_en <= en;
      fifo_overflow <= ov;
      rd(OFS_FIP, {18'h00000, ev & en});
      rd(OFS_OVF, {18'h00000, ov});
    end
    // wake-up detection, unfiltered then through the line filter
    for (int f = 0; f < 2; f++) begin
      wk_on <= 1'b0;
      wk_filt <= f[0];
      wr(OFS_CFG, {9'h000, f[0], 22'h000402});
      repeat (2) @(posedge aclk);
      wk_on <= 1'b1;
      repeat (800) @(posedge aclk);
    end
    wk_on <= 1'b0;
    // unmapped addresses answer with an error and zero data
    rd(5'h14, {RESP_SLVERR, 32'h00000000});
    rd(5'h1C, {RESP_SLVERR, 32'h00000000});
    repeat (4) @(posedge aclk);
    if (exp_q.size() != 0) chk(34'(exp_q.size()), 34'h0, "missing answers");
    results();
  end
endmodule
`default_nettype wire

// [dv/can_node_model.sv]
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus line and quantum timing
  output logic can_rx,
  output logic tq_tick,
  output logic sample_point
);
  logic [1:0] pre_q; // four clocks per quantum
  logic [3:0] tq_q; // ten quanta per bit, sample after the seventh
  integer seed = 5;
  // the line moves only at a bit boundary, far from the sample point,
  // so single and triple sampling must both see the same level
  always @(posedge aclk) begin
    pre_q <= aresetn ? pre_q + 2'h1 : 2'h0;
    tq_tick <= aresetn && pre_q == 2'h3;
    sample_point <= aresetn && pre_q == 2'h3 && tq_q == 4'h6;
    if (!aresetn) begin
      tq_q <= 4'h0;
      can_rx <= 1'b1;
    end else if (tq_tick) begin
      tq_q <= (tq_q == 4'h9) ? 4'h0 : tq_q + 4'h1;
      // random bits give low stretches long enough to wake
      if (tq_q == 4'h9) can_rx <= 1'($random(seed));
    end
  end
endmodule
`default_nettype wire

// [verilog/can_bit_timing_error_status.sv]
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_error_status
  import can_bt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // protocol engine status
  input wire logic [8:0] tx_err_count,
  input wire logic [7:0] rx_err_count,
  input wire logic [NFIFO-1:0] fifo_event,
  input wire logic [NFIFO-1:0] fifo_event_en,
  input wire logic [NFIFO-1:0] fifo_overflow,
  // bus line and quantum timing
  input wire logic can_rx,
  input wire logic tq_tick,
  input wire logic sample_point,
  // timing results to the bit engine
  output logic [3:0] phase_seg1_tq,
  output logic [3:0] phase_seg2_tq,
  output logic [4:0] quanta_per_bit,
  output logic triple_sample_sel,
  output logic sampled_bit,
  output logic wake_detect,
  output logic [2:0] operating_mode_field
);

  // whole module state
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ctl;
    logic [31:0] est;
    logic [NFIFO-1:0] fip;
    logic [NFIFO-1:0] ovf;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] hist;
    logic bit_s;
    logic [4:0] lowcnt;
    logic rx_prev;
    logic wake;
    logic [3:0] seg1;
    logic [3:0] seg2;
    logic [4:0] qpb;
  } state_s;

  state_s s_q; // registered state
  state_s s_d; // next state

  // byte-lane mask from the held write strobes
  logic [31:0] lane_mask;
  // per-FIFO pending from enabled events
  logic [NFIFO-1:0] fip_next;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{s_q.wstb[gi]}};
    end
    for (gi = 0; gi < NFIFO; gi++) begin : g_fifo
      // pending only while that fifo's interrupt is both raised and enabled
      assign fip_next[gi] = fifo_event[gi] & fifo_event_en[gi];
    end
  endgenerate

  // majority of three quantum samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // decoded fields of the timing and control registers, error count terms and write terms
  logic [3:0] seg1_len;
  logic [3:0] seg2_len;
  logic [3:0] prop_len;
  logic [3:0] seg2_auto;
  logic [8:0] tx_sat;
  logic tx_warn;
  logic rx_warn;
  logic in_config;
  logic do_write;
  logic [31:0] wr_val;

  // next-state logic
  always_comb begin
    s_d = s_q;
    // lengths are field value plus one quantum
    seg1_len = {1'b0, s_q.cfg[SEG1_HI:SEG1_LO]} + ONE_TQ;
    seg2_len = {1'b0, s_q.cfg[SEG2_HI:SEG2_LO]} + ONE_TQ;
    prop_len = {1'b0, s_q.cfg[PRSEG_HI:PRSEG_LO]} + ONE_TQ;
    // automatic seg2 is the larger of seg1 and processing time
    seg2_auto = (seg1_len > IPT_TQ) ? seg1_len : IPT_TQ;
    in_config = (s_q.ctl[MODE_HI:MODE_LO] == MODE_CONFIG);
    tx_sat = (tx_err_count > CNT_SAT) ? CNT_SAT : tx_err_count;
    tx_warn = (tx_err_count >= LIM_WARN) && (tx_err_count < LIM_PASSIVE);
    rx_warn = ({1'b0, rx_err_count} >= LIM_WARN) && ({1'b0, rx_err_count} < LIM_PASSIVE);
    do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    wr_val = s_q.wdat & lane_mask;

    // timing results, registered so outputs come from flops
    s_d.seg1 = seg1_len;
    s_d.seg2 = s_q.cfg[SEG2TS_BIT] ? seg2_len : seg2_auto;
    // sync quantum plus prop, seg1 and effective seg2
    s_d.qpb = 5'(ONE_TQ) + 5'(prop_len) + 5'(seg1_len) + 5'(s_d.seg2);

    // error state word; bits above the flags stay zero
    s_d.est = '0;
    s_d.est[TX_OFF_BIT] = (tx_err_count >= LIM_BUS_OFF);
    s_d.est[TX_PASSIVE_BIT] = (tx_err_count >= LIM_PASSIVE);
    s_d.est[RX_PASSIVE_BIT] = ({1'b0, rx_err_count} >= LIM_PASSIVE);
    s_d.est[TX_WARN_BIT] = tx_warn;
    s_d.est[RX_WARN_BIT] = rx_warn;
    s_d.est[ANY_WARN_BIT] = tx_warn | rx_warn;
    // counter fields track the engine; transmit saturates at all ones
    s_d.est[15:8] = tx_sat[7:0];
    s_d.est[7:0] = rx_err_count;

    // fifo status follows the engine levels
    s_d.fip = fip_next;
    s_d.ovf = fifo_overflow;

    // three-sample history, shifted once per quantum
    if (tq_tick) begin
      s_d.hist = {s_q.hist[1:0], can_rx};
    end
    // at the sample point take one or three samples
    if (sample_point) begin
      if (s_q.cfg[TRIPLE_BIT]) begin
        s_d.bit_s = maj3(s_q.hist);
      end else begin
        s_d.bit_s = can_rx;
      end
    end

    // wake-up: filtered waits for a held dominant level, unfiltered does not
    s_d.rx_prev = can_rx;
    if (can_rx) begin
      s_d.lowcnt = '0;
    end else if (s_q.lowcnt != 5'(WAKE_FILT_CYC)) begin
      s_d.lowcnt = s_q.lowcnt + 5'h01;
    end
    if (s_q.cfg[WAKE_FILT_BIT]) begin
      // short glitches never reach the count, so they cannot wake the node
      s_d.wake = !can_rx && (s_q.lowcnt == WAKE_FILT_LAST);
    end else begin
      s_d.wake = s_q.rx_prev && !can_rx;
    end

    // write address channel
    if (awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.waddr = awaddr;
    end
    // write data channel
    if (wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.wdat = wdata;
      s_d.wstb = wstrb;
    end
    // perform the write once both halves are held
    if (do_write) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case ({s_q.waddr[ADDR_W-1:2], 2'b00})
        OFS_CFG: begin
          // outside configuration mode the write is dropped silently
          if (in_config) begin
            s_d.cfg = (s_q.cfg & ~(CFG_WMASK & lane_mask)) | (wr_val & CFG_WMASK);
          end
        end
        OFS_CTL: begin
          s_d.ctl = (s_q.ctl & ~(CTL_WMASK & lane_mask)) | (wr_val & CTL_WMASK);
        end
        OFS_ERR, OFS_FIP, OFS_OVF: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    // response taken, free both halves
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
    end
    s_d.awready = !s_d.aw_full;
    s_d.wready = !s_d.w_full;

    // read channel: one read under way at a time
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case ({araddr[ADDR_W-1:2], 2'b00})
        OFS_CFG: s_d.rdata = s_q.cfg;
        OFS_ERR: s_d.rdata = s_q.est;
        OFS_FIP: s_d.rdata = {16'h0000, s_q.fip};
        OFS_OVF: s_d.rdata = {16'h0000, s_q.ovf};
        OFS_CTL: s_d.rdata = s_q.ctl;
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;
  end

  // state register; synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
      s_q.ctl <= CTL_RESET;
      s_q.hist <= 3'h7;
      s_q.bit_s <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.seg1 <= ONE_TQ;
      s_q.seg2 <= IPT_TQ;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign phase_seg1_tq = s_q.seg1;
  assign phase_seg2_tq = s_q.seg2;
  assign quanta_per_bit = s_q.qpb;
  assign triple_sample_sel = s_q.cfg[TRIPLE_BIT];
  assign sampled_bit = s_q.bit_s;
  assign wake_detect = s_q.wake;
  assign operating_mode_field = s_q.ctl[MODE_HI:MODE_LO];

  // checks on the design's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bus_off_flag: assert property ((tx_err_count >= LIM_BUS_OFF) |=> s_q.est[TX_OFF_BIT])
    else $error("bus-off flag missing");
  a_tx_passive_flag: assert property ((tx_err_count < LIM_PASSIVE) |=> !s_q.est[TX_PASSIVE_BIT])
    else $error("transmit passive flag wrong");
  a_rx_passive_flag: assert property (({1'b0, rx_err_count} >= LIM_PASSIVE) |=> s_q.est[RX_PASSIVE_BIT])
    else $error("receive passive flag missing");
  a_tx_warn_band: assert property (##1 s_q.est[TX_WARN_BIT] == ($past(tx_err_count) >= LIM_WARN && $past(tx_err_count) < LIM_PASSIVE))
    else $error("transmit warning band wrong");
  a_rx_warn_band: assert property (s_q.est[RX_WARN_BIT] |-> s_q.est[7:5] == 3'h3)
    else $error("receive warning band wrong");
  a_any_warn: assert property (s_q.est[ANY_WARN_BIT] == (s_q.est[TX_WARN_BIT] | s_q.est[RX_WARN_BIT]))
    else $error("combined warning mismatch");
  a_seg2_select: assert property (s_q.cfg[SEG2TS_BIT] && $stable(s_q.cfg) |=> s_q.seg2 == {1'b0, $past(s_q.cfg[SEG2_HI:SEG2_LO])} + ONE_TQ)
    else $error("programmed seg2 not applied");
  a_seg2_auto: assert property (!s_q.cfg[SEG2TS_BIT] && $stable(s_q.cfg) |=> s_q.seg2 >= s_q.seg1 && s_q.seg2 >= IPT_TQ)
    else $error("automatic seg2 too short");
  a_cfg_locked: assert property (s_q.aw_full && s_q.w_full && !s_q.bvalid && s_q.ctl[MODE_HI:MODE_LO] != MODE_CONFIG |=> $stable(s_q.cfg))
    else $error("timing written outside config mode");
  a_cfg_reserved: assert property (s_q.cfg[31:23] == 9'h000 && s_q.cfg[21:19] == 3'h0)
    else $error("unimplemented timing bits set");
  a_fifo_pending: assert property (##1 s_q.fip == ($past(fifo_event) & $past(fifo_event_en)))
    else $error("fifo pending mismatch");
  a_fifo_overflow: assert property (##1 s_q.ovf == $past(fifo_overflow))
    else $error("overflow pending mismatch");
  a_single_sample: assert property (sample_point && !s_q.cfg[TRIPLE_BIT] |=> s_q.bit_s == $past(can_rx))
    else $error("single sample wrong");

endmodule
`default_nettype wire

// [verilog/can_bt_pkg.sv]
// Functional notes
// - filter enable gates wake-up line filtering
// - phase segment 2 length is field plus one
// - free select picks field, else max(seg1,ipt)
// - triple sample bit selects three-sample majority
// - phase segment 1 length is field plus one
// - seg2 within seg1, jump within seg2; not enforced here, the seg2 field is applied as written
// - timing writes only in configuration mode
// - bus-off flag when transmit count reaches 256
// - transmit passive flag at count 128 up
// - receive passive flag at count 128 up
// - transmit warning flag for 96 to 127
// - receive warning flag for 96 to 127
// - combined warning when either side warns
// - read-only error counters reset to zero
// - per-FIFO pending bit of enabled interrupts
// - unimplemented bits read as zero
// - per-FIFO receive overflow pending bit
package can_bt_pkg;
  // register byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CFG = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ERR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_FIP = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_OVF = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTL = 5'h10;
  // timing register fields
  localparam int WAKE_FILT_BIT = 22;
  localparam int SEG2_HI = 18;
  localparam int SEG2_LO = 16;
  localparam int SEG2TS_BIT = 15;
  localparam int TRIPLE_BIT = 14;
  localparam int SEG1_HI = 13;
  localparam int SEG1_LO = 11;
  localparam int PRSEG_HI = 10;
  localparam int PRSEG_LO = 8;
  localparam logic [31:0] CFG_WMASK = 32'h0047FFFF;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  // control register mode field
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 21;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [31:0] CTL_WMASK = 32'h00E00000;
  localparam logic [31:0] CTL_RESET = 32'h00800000;
  // error state fields
  localparam int TX_OFF_BIT = 21;
  localparam int TX_PASSIVE_BIT = 20;
  localparam int RX_PASSIVE_BIT = 19;
  localparam int TX_WARN_BIT = 18;
  localparam int RX_WARN_BIT = 17;
  localparam int ANY_WARN_BIT = 16;
  localparam logic [8:0] LIM_BUS_OFF = 9'h100;
  localparam logic [8:0] LIM_PASSIVE = 9'h080;
  localparam logic [8:0] LIM_WARN = 9'h060;
  localparam logic [8:0] CNT_SAT = 9'h0FF;
  // quanta figures
  localparam logic [3:0] IPT_TQ = 4'h2;
  localparam logic [3:0] ONE_TQ = 4'h1;
  // wake-up line filter time
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_FILT_NS = 100;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] WAKE_FILT_LAST = 5'(WAKE_FILT_CYC - 1);
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NFIFO = 16;
endpackage
